// [core/eirq_map.svh]
`ifndef EIRQ_MAP_SVH
`define EIRQ_MAP_SVH

// ****************************************************************
// Register indices, byte address is four times the index.
// ****************************************************************
`define EIRQ_IDX_MODE_HI  8'hCA
`define EIRQ_IDX_MODE_LO  8'hCB
`define EIRQ_IDX_REQ0     8'hCC
`define EIRQ_IDX_GRP      8'hCD
`define EIRQ_IDX_MODE_P1  8'hD7
`define EIRQ_IDX_REQ1     8'hD8
`define EIRQ_IDX_STAT     8'hE0
`define EIRQ_IDX_MASK     8'hE1

// ****************************************************************
// Reset values and field positions.
// ****************************************************************
`define EIRQ_RST_BYTE     8'h00
`define EIRQ_RST_SRC      12'h000
`define EIRQ_REQ1_W       4
`define EIRQ_NUM_SRC      12
`define EIRQ_FALL_BIT     0
`define EIRQ_RISE_BIT     1
`define EIRQ_MODE_OFF     2'h0
`define EIRQ_MODE_FALL    2'h1
`define EIRQ_MODE_RISE    2'h2
`define EIRQ_MODE_BOTH    2'h3

`endif

// [core/eirq_pkg.sv]
`include "eirq_map.svh"

package eirq_pkg;

    // ****************************************************************
    // Edge modes of one source.
    // ****************************************************************
    typedef enum logic [1:0] {
        EIRQ_OFF  = `EIRQ_MODE_OFF,
        EIRQ_FALL = `EIRQ_MODE_FALL,
        EIRQ_RISE = `EIRQ_MODE_RISE,
        EIRQ_BOTH = `EIRQ_MODE_BOTH
    } eirq_mode_t;

    typedef logic [`EIRQ_NUM_SRC-1:0] eirq_src_vec_t;

endpackage

// [core/eirq_edge.sv]
`timescale 1ns/1ps
`include "eirq_map.svh"

module eirq_edge
    import eirq_pkg::*;
#(
    parameter int N = `EIRQ_NUM_SRC
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           ce_i,
    input  wire logic [N-1:0]   pin_i,
    input  wire logic [2*N-1:0] mode_i,
    output logic      [N-1:0]   edge_o
);

    logic         armed_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] edge_q;
    logic [N-1:0] hit;

    // ****************************************************************
    // Per-pin edge detection.
    // ****************************************************************
    for (genvar i = 0; i < N; i++) begin : g_bit
        wire fall = armed_q & prev_q[i] & ~pin_i[i];
        wire rise = armed_q & ~prev_q[i] & pin_i[i];
        assign hit[i] = (mode_i[2*i+`EIRQ_FALL_BIT] & fall) | (mode_i[2*i+`EIRQ_RISE_BIT] & rise);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
            prev_q  <= '0;
            edge_q  <= '0;
        end else if (ce_i) begin
            armed_q <= 1'b1;
            prev_q  <= pin_i;
            edge_q  <= hit;
        end
    end

    assign edge_o = edge_q;

endmodule

// [core/eirq_flags.sv]
`timescale 1ns/1ps
`include "eirq_map.svh"

module eirq_flags
    import eirq_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        CLK_EN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic [11:0] EXT_PIN_I,
    input  wire logic        GLOBAL_IE_I,
    input  wire logic        VECTOR_ACK_I,
    input  wire logic [3:0]  VECTOR_SRC_I,
    output logic      [11:0] IRQ_REQ_O,
    output logic             IRQ_O
);

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0]          mode_hi_q;
    logic [7:0]          mode_lo_q;
    logic [7:0]          mode_p1_q;
    logic [7:0]          req0_q;
    logic [3:0]          req1_q;
    logic [7:0]          grp_q;
    eirq_src_vec_t       stat_q;
    eirq_src_vec_t       mask_q;
    eirq_src_vec_t       irq_req_q;
    logic                dph_wr_q;
    logic                dph_rd_q;
    logic                rd_done_q;
    logic                hit_q;
    logic [7:0]          addr_q;
    logic [31:0]         hrdata_q;

    // ****************************************************************
    // Source-ordered views of the register layouts, and register-ordered views of the source vectors.
    // ****************************************************************
    logic [23:0]         mode_src;
    eirq_src_vec_t       ev;
    eirq_src_vec_t       clr_src;
    eirq_src_vec_t       pend_src;
    logic [7:0]          ev_r0;
    logic [3:0]          ev_r1;
    logic [7:0]          ev_g;
    logic [7:0]          clr_r0;
    logic [3:0]          clr_r1;

    assign mode_src = {mode_lo_q[3:0], mode_p1_q, mode_hi_q, mode_lo_q[7:4]};
    assign pend_src = {req0_q[1:0], req1_q, req0_q[7:2]};
    assign ev_r0    = {ev[5:0], ev[11:10]};
    assign ev_r1    = ev[9:6];
    assign ev_g     = {ev[0], ev[2], ev[4], ev[7], ev[8], ev[9], ev[10], ev[11]};
    assign clr_src  = VECTOR_ACK_I ? (12'h001 << VECTOR_SRC_I) : 12'h000;
    assign clr_r0   = {clr_src[5:0], clr_src[11:10]};
    assign clr_r1   = clr_src[9:6];

    eirq_edge #(
        .N (`EIRQ_NUM_SRC)
    ) u_edge (
        .clk_i  (REF_CLK_I),
        .rst_i  (SYS_RST_I),
        .ce_i   (CLK_EN_I),
        .pin_i  (EXT_PIN_I),
        .mode_i (mode_src),
        .edge_o (ev)
    );

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire accept  = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire map_ok  = (HADDR_I[31:10] == 22'h000000) & (HADDR_I[1:0] == 2'h0);
    wire wr_ok   = dph_wr_q & hit_q & HREADY_I;
    wire wr_mhi  = wr_ok & (addr_q == `EIRQ_IDX_MODE_HI);
    wire wr_mlo  = wr_ok & (addr_q == `EIRQ_IDX_MODE_LO);
    wire wr_mp1  = wr_ok & (addr_q == `EIRQ_IDX_MODE_P1);
    wire wr_req0 = wr_ok & (addr_q == `EIRQ_IDX_REQ0);
    wire wr_req1 = wr_ok & (addr_q == `EIRQ_IDX_REQ1);
    wire wr_grp  = wr_ok & (addr_q == `EIRQ_IDX_GRP);
    wire wr_stat = wr_ok & (addr_q == `EIRQ_IDX_STAT);
    wire wr_mask = wr_ok & (addr_q == `EIRQ_IDX_MASK);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_q) begin
            unique case (addr_q)
                `EIRQ_IDX_MODE_HI: rd_mux = {24'h000000, mode_hi_q};
                `EIRQ_IDX_MODE_LO: rd_mux = {24'h000000, mode_lo_q};
                `EIRQ_IDX_MODE_P1: rd_mux = {24'h000000, mode_p1_q};
                `EIRQ_IDX_REQ0:    rd_mux = {24'h000000, req0_q};
                `EIRQ_IDX_REQ1:    rd_mux = {28'h0000000, req1_q};
                `EIRQ_IDX_GRP:     rd_mux = {24'h000000, grp_q};
                `EIRQ_IDX_STAT:    rd_mux = {20'h00000, stat_q};
                `EIRQ_IDX_MASK:    rd_mux = {20'h00000, mask_q};
                default:           rd_mux = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Next values; a vector clear beats a write, an edge beats both.
    // ****************************************************************
    wire [7:0]     req0_d = ((wr_req0 ? HWDATA_I[7:0] : req0_q) & ~clr_r0) | ev_r0;
    wire [3:0]     req1_d = ((wr_req1 ? HWDATA_I[3:0] : req1_q) & ~clr_r1) | ev_r1;
    wire [7:0]     grp_d  = (wr_grp ? HWDATA_I[7:0] : grp_q) | ev_g;
    wire [11:0]    stat_d = (stat_q & ~(wr_stat ? HWDATA_I[11:0] : 12'h000)) | ev;
    wire [11:0]    req_d  = pend_src & {12{GLOBAL_IE_I}};

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            mode_hi_q <= `EIRQ_RST_BYTE;
            mode_lo_q <= `EIRQ_RST_BYTE;
            mode_p1_q <= `EIRQ_RST_BYTE;
            req0_q    <= `EIRQ_RST_BYTE;
            req1_q    <= 4'h0;
            grp_q     <= `EIRQ_RST_BYTE;
            stat_q    <= `EIRQ_RST_SRC;
            mask_q    <= `EIRQ_RST_SRC;
            irq_req_q <= `EIRQ_RST_SRC;
        end else if (CLK_EN_I) begin
            mode_hi_q <= wr_mhi ? HWDATA_I[7:0] : mode_hi_q;
            mode_lo_q <= wr_mlo ? HWDATA_I[7:0] : mode_lo_q;
            mode_p1_q <= wr_mp1 ? HWDATA_I[7:0] : mode_p1_q;
            req0_q    <= req0_d;
            req1_q    <= req1_d;
            grp_q     <= grp_d;
            stat_q    <= stat_d;
            mask_q    <= wr_mask ? HWDATA_I[11:0] : mask_q;
            irq_req_q <= req_d;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            dph_wr_q  <= 1'b0;
            dph_rd_q  <= 1'b0;
            rd_done_q <= 1'b0;
            hit_q     <= 1'b0;
            addr_q    <= 8'h00;
            hrdata_q  <= 32'h00000000;
        end else if (CLK_EN_I) begin
            if (HREADY_I) begin
                dph_wr_q  <= accept & HWRITE_I;
                dph_rd_q  <= accept & ~HWRITE_I;
                rd_done_q <= 1'b0;
                hit_q     <= map_ok;
                addr_q    <= HADDR_I[9:2];
            end else if (dph_rd_q) begin
                rd_done_q <= 1'b1;
                hrdata_q  <= rd_mux;
            end
        end
    end

    assign HREADYOUT_O = ~dph_rd_q | rd_done_q;
    assign HRDATA_O    = hrdata_q;
    assign HRESP_O     = 1'b0;
    assign IRQ_REQ_O   = irq_req_q;
    assign IRQ_O       = |(stat_q & mask_q);

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_vec_clears_req: assert property (CLK_EN_I && VECTOR_ACK_I && VECTOR_SRC_I < 4'hC && ev == 12'h000
        && !wr_req0 && !wr_req1 |=> pend_src[$past(VECTOR_SRC_I)] == 1'b0)
        else $error("Vectored request bit not cleared.");

    a_req0_write: assert property (CLK_EN_I && wr_req0 && !VECTOR_ACK_I && ev == 12'h000
        |=> req0_q == $past(HWDATA_I[7:0]))
        else $error("First request register did not take write data.");

    a_req1_upper: assert property (CLK_EN_I && dph_rd_q && !rd_done_q && hit_q
        && addr_q == `EIRQ_IDX_REQ1 |=> HRDATA_O[31:4] == 28'h0000000 && HRDATA_O[3:0] == $past(req1_q))
        else $error("Second request register read is wrong.");

    a_grp_set_map: assert property (CLK_EN_I && ev[0] |=> grp_q[7] && req0_q[2])
        else $error("Source zero did not set its group and request bits.");

    a_grp_no_vec: assert property (CLK_EN_I && VECTOR_ACK_I && !wr_grp && ev == 12'h000
        |=> grp_q == $past(grp_q))
        else $error("Vectoring changed the group flags.");

    a_req_to_cpu: assert property (CLK_EN_I && ev != 12'h000 && GLOBAL_IE_I
        ##1 CLK_EN_I && GLOBAL_IE_I |=> (IRQ_REQ_O & $past(ev, 2)) == $past(ev, 2))
        else $error("Detected edge did not request service.");

    a_mode_off_quiet: assert property (CLK_EN_I && mode_src[1:0] == `EIRQ_MODE_OFF
        && $stable(mode_src[1:0]) |=> !ev[0])
        else $error("Disabled source produced an edge.");

    a_edge_sets_req: assert property (CLK_EN_I && ev != 12'h000
        |=> (pend_src & $past(ev)) == $past(ev) && (stat_q & $past(ev)) == $past(ev))
        else $error("Edge did not set pending and status flags.");

    c_vec_clear: cover property (CLK_EN_I && VECTOR_ACK_I && pend_src != 12'h000);
    c_grp_event: cover property (CLK_EN_I && ev_g != 8'h00 ##1 IRQ_O);
    c_reg_read:  cover property (CLK_EN_I && dph_rd_q && !rd_done_q ##1 HREADYOUT_O);

endmodule

// [dv/eirq_flags_tb_top.sv]
`timescale 1ns/1ps
`include "eirq_map.svh"

module eirq_flags_tb_top
    import eirq_pkg::*;
;
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        ce          = 1'b1;
    logic        hsel        = 1'b0;
    logic [1:0]  htrans      = 2'h0;
    logic [31:0] haddr       = 32'h0;
    logic        hwrite      = 1'b0;
    logic [31:0] hwdata      = 32'h0;
    logic [11:0] pin         = 12'h000;
    logic        gie         = 1'b0;
    logic        vack        = 1'b0;
    logic [3:0]  vsrc        = 4'h0;
    wire  [31:0] hrdata;
    wire         hready;
    wire         hresp;
    wire  [11:0] irq_req;
    wire         irq;
    int          bad_count   = 0;
    int          check_count = 0;
    int          i;
    int          s;
    logic [1:0]  m;
    logic        up;
    logic        g;
    logic        mk;
    logic        e;
    logic [31:0] d;
    logic [31:0] gm;
    logic [7:0]  tab [8]     = '{`EIRQ_IDX_MODE_HI, `EIRQ_IDX_MODE_LO, `EIRQ_IDX_REQ0, `EIRQ_IDX_GRP,
                                 `EIRQ_IDX_MODE_P1, `EIRQ_IDX_REQ1, `EIRQ_IDX_STAT, `EIRQ_IDX_MASK};
    logic [7:0]  gtab [12]   = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h20, 8'h00,
                                 8'h00, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

    eirq_flags i_eirq_flags (
        .REF_CLK_I    (clk),
        .SYS_RST_I    (rst),
        .CLK_EN_I     (ce),
        .HSEL_I       (hsel),
        .HADDR_I      (haddr),
        .HTRANS_I     (htrans),
        .HWRITE_I     (hwrite),
        .HSIZE_I      (3'h2),
        .HWDATA_I     (hwdata),
        .HREADY_I     (hready),
        .HRDATA_O     (hrdata),
        .HREADYOUT_O  (hready),
        .HRESP_O      (hresp),
        .EXT_PIN_I    (pin),
        .GLOBAL_IE_I  (gie),
        .VECTOR_ACK_I (vack),
        .VECTOR_SRC_I (vsrc),
        .IRQ_REQ_O    (irq_req),
        .IRQ_O        (irq)
    );

    always #5 clk = ~clk;

    // ****************************************************************
    // Bus access and comparison helpers.
    // ****************************************************************
    function automatic logic [31:0] ad(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction

    function automatic logic [7:0] mode_idx(input int n);
        return (n inside {[2:5]}) ? `EIRQ_IDX_MODE_HI :
               (n inside {[6:9]}) ? `EIRQ_IDX_MODE_P1 : `EIRQ_IDX_MODE_LO;
    endfunction

    function automatic int mode_sh(input int n);
        return (n < 2) ? 2 * n + 4 : (n < 6) ? 2 * (n - 2) : (n < 10) ? 2 * (n - 6) : 2 * (n - 10);
    endfunction

    function automatic logic [7:0] req_idx(input int n);
        return (n inside {[6:9]}) ? `EIRQ_IDX_REQ1 : `EIRQ_IDX_REQ0;
    endfunction

    function automatic int req_bit(input int n);
        return (n < 6) ? n + 2 : (n < 10) ? n - 6 : n - 10;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] dat, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr_en;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] dat);
        logic [31:0] r;
        bus(1'b1, a, dat, r);
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        void'($urandom(32'h8AE7F754));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (tab[k]) rd(ad(tab[k]), 32'h0);
        chk({31'h0, hresp}, 32'h0);
        d = $urandom;
        wr(ad(`EIRQ_IDX_REQ0), d);
        rd(ad(`EIRQ_IDX_REQ0), d & 32'hFF);
        wr(ad(`EIRQ_IDX_REQ1), 32'hFF);
        rd(ad(`EIRQ_IDX_REQ1), 32'h0F);
        wr(ad(`EIRQ_IDX_GRP), d >> 8);
        rd(ad(`EIRQ_IDX_GRP), (d >> 8) & 32'hFF);
        wr(ad(`EIRQ_IDX_MASK), d);
        rd(ad(`EIRQ_IDX_MASK), d & 32'hFFF);
        wr(ad(`EIRQ_IDX_STAT), 32'hFFF);
        rd(ad(`EIRQ_IDX_STAT), 32'h0);
        wr(ad(8'hCE), 32'hFFFFFFFF);
        rd(ad(8'hCE), 32'h0);
        rd(32'h00001334, 32'h0);
        for (i = 0; i < 24; i++) begin
            s  = $urandom_range(11);
            m  = 2'(i % 4);
            up = 1'($urandom);
            g  = 1'($urandom);
            mk = 1'($urandom);
            e  = up ? m[1] : m[0];
            gm = e ? 32'(gtab[s]) : 32'h0;
            pin[s] <= ~up;
            gie    <= g;
            repeat (4) @(posedge clk);
            wr(ad(mode_idx(s)), 32'(m) << mode_sh(s));
            rd(ad(mode_idx(s)), 32'(m) << mode_sh(s));
            wr(ad(`EIRQ_IDX_MASK), 32'(mk) << s);
            wr(ad(`EIRQ_IDX_REQ0), 32'h0);
            wr(ad(`EIRQ_IDX_REQ1), 32'h0);
            wr(ad(`EIRQ_IDX_GRP), 32'h0);
            wr(ad(`EIRQ_IDX_STAT), 32'hFFF);
            pin[s] <= up;
            ce     <= ~i[0];
            repeat (4) @(posedge clk);
            chk({31'h0, irq}, i[0] ? 32'h0 : 32'(e & mk));
            chk({20'h0, irq_req}, i[0] ? 32'h0 : 32'(e & g) << s);
            ce <= 1'b1;
            repeat (4) @(posedge clk);
            rd(ad(req_idx(s)), 32'(e) << req_bit(s));
            rd(ad(`EIRQ_IDX_GRP), gm);
            rd(ad(`EIRQ_IDX_STAT), 32'(e) << s);
            chk({31'h0, irq}, 32'(e & mk));
            chk({20'h0, irq_req}, 32'(e & g) << s);
            vack <= 1'b1;
            vsrc <= 4'(s);
            @(posedge clk);
            vack <= 1'b0;
            repeat (2) @(posedge clk);
            rd(ad(req_idx(s)), 32'h0);
            rd(ad(`EIRQ_IDX_GRP), gm);
            chk({20'h0, irq_req}, 32'h0);
            wr(ad(`EIRQ_IDX_STAT), 32'(e) << s);
            rd(ad(`EIRQ_IDX_STAT), 32'h0);
            chk({31'h0, irq}, 32'h0);
            wr(ad(mode_idx(s)), 32'h0);
        end
        wrap_up();
    end

    initial begin
        #300000;
        bad_count++;
        wrap_up();
    end
endmodule
